// ==== hw/nid_pkg.sv ====
// Package for the node identifier low half and config ROM mapping registers.
// Assumes an APB slave with 32-bit data on one clock.
package nid_pkg;
  localparam logic [7:0]  NID_OFS_ID_LOW    = 8'h28;
  localparam logic [7:0]  NID_OFS_ROM_BASE  = 8'h34;
  localparam logic [7:0]  NID_OFS_ID_STATUS = 8'h5c;
  localparam logic [31:0] NID_ID_LOW_RST    = 32'h00000000;
  localparam logic [31:0] NID_ROM_BASE_RST  = 32'h00000000;
  localparam int          NID_ROM_RSVD_W    = 10;
  localparam logic [31:0] NID_ROM_BASE_MASK = 32'hfffffc00;
  localparam int          NID_ST_LOCKED     = 0;
  localparam int          NID_ST_FROM_SROM  = 1;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } nid_apb_req_t;

  typedef struct packed {
    logic        prdata_valid;
    logic [31:0] prdata;
    logic        pslverr;
  } nid_apb_rsp_t;

  typedef enum logic [2:0] {
    NID_EMPTY   = 3'b001,
    NID_SROM_LD = 3'b010,
    NID_LOCKED  = 3'b100
  } nid_id_state_t;
endpackage

// ==== hw/nid_rom_addr.sv ====
// Forms the host memory address for a config ROM quadlet read.
// Assumes request strobe and offset come from logic on core_clk.
`timescale 1ns/10ps
`default_nettype none
module nid_rom_addr (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Request
  input  wire logic        reqValid,
  input  wire logic [9:0]  reqOffset,
  input  wire logic [31:0] romBase,
  // Answer
  output var  logic        hostAddrValid,
  output var  logic [31:0] hostAddr
);
  import nid_pkg::*;
  logic        next_hostAddrValid;
  logic [31:0] next_hostAddr;

  always_comb begin
    next_hostAddrValid = reqValid;
    next_hostAddr      = hostAddr;
    if (reqValid) begin
      next_hostAddr = romBase + {22'h000000, reqOffset};
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hostAddrValid <= 1'b0;
      hostAddr      <= 32'h00000000;
    end else begin
      hostAddrValid <= next_hostAddrValid;
      hostAddr      <= next_hostAddr;
    end
  end

  a_addr_sum: assert property (@(posedge core_clk) disable iff (!rst_b)
    reqValid |=> hostAddrValid && hostAddr ==
      $past(romBase) + {22'h000000, $past(reqOffset)})
    else $error("config ROM host address wrong");
endmodule
`default_nettype wire

// ==== hw/nid_regs.sv ====
// Node identifier low quadlet and config ROM mapping register bank.
// Assumes an APB master on core_clk and a serial ROM loader on core_clk.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module nid_regs (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  // APB slave
  input  wire nid_pkg::nid_apb_req_t apbReq,
  output var  logic                  pready,
  output var  logic [31:0]           prdata,
  output var  logic                  pslverr,
  // Serial ROM loader
  input  wire logic                  sromPresent,
  input  wire logic                  sromLoadValid,
  input  wire logic [31:0]           sromLoadData,
  // Config ROM read requests from the link
  input  wire logic                  romReqValid,
  input  wire logic [9:0]            romReqOffset,
  output var  logic                  romHostAddrValid,
  output var  logic [31:0]           romHostAddr,
  // Identifier out
  output var  logic [31:0]           nodeIdLow,
  output var  logic                  nodeIdLocked
);
  import nid_pkg::*;

  // Edges after reset release before the strap has crossed both stages
  localparam logic [1:0] StrapWaitCnt = 2'h2;

  nid_id_state_t idState;
  nid_id_state_t next_idState;
  logic [31:0]   next_nodeIdLow;
  logic [31:0]   romBase;
  logic [31:0]   next_romBase;
  logic          next_pready;
  logic [31:0]   next_prdata;
  logic          next_pslverr;
  logic          sromPresSync1;
  logic          sromPresSync2;
  logic          sromAtReset;
  logic          sromCaught;
  logic [1:0]    strapCnt;
  logic          accessEdge;
  logic          wrId;
  logic          wrRom;

  // Strap synchroniser; the level is caught once, on the third edge after
  // reset release, because the second stage still holds its reset value
  // on the first two
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sromPresSync1 <= 1'b0;
      sromPresSync2 <= 1'b0;
      strapCnt      <= 2'h0;
      sromCaught    <= 1'b0;
      sromAtReset   <= 1'b0;
    end else begin
      sromPresSync1 <= sromPresent;
      sromPresSync2 <= sromPresSync1;
      if (!sromCaught) begin
        strapCnt <= strapCnt + 2'h1;
        if (strapCnt == StrapWaitCnt) begin
          sromCaught  <= 1'b1;
          sromAtReset <= sromPresSync2;
        end
      end
    end
  end

  // Zero-wait slave: answer in the access phase's first cycle
  assign accessEdge = apbReq.psel && apbReq.penable && pready;
  assign wrId  = accessEdge && apbReq.pwrite &&
                 apbReq.paddr == NID_OFS_ID_LOW;
  assign wrRom = accessEdge && apbReq.pwrite &&
                 apbReq.paddr == NID_OFS_ROM_BASE;

  always_comb begin
    next_idState   = idState;
    next_nodeIdLow = nodeIdLow;
    unique case (idState)
      NID_EMPTY: begin
        if (sromCaught && sromAtReset) begin
          next_idState = NID_SROM_LD;
        end else if (sromCaught && wrId) begin
          next_nodeIdLow = apbReq.pwdata;
          next_idState   = NID_LOCKED;
        end
      end
      NID_SROM_LD: begin
        // Software writes are dropped while waiting for the loader
        if (sromLoadValid) begin
          next_nodeIdLow = sromLoadData;
          next_idState   = NID_LOCKED;
        end
      end
      NID_LOCKED: begin
        next_idState = NID_LOCKED;
      end
      default: next_idState = NID_EMPTY;
    endcase
  end

  always_comb begin
    next_romBase = romBase;
    if (wrRom) begin
      next_romBase = apbReq.pwdata & NID_ROM_BASE_MASK;
    end
  end

  always_comb begin
    next_pready  = apbReq.psel && !apbReq.penable;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (apbReq.psel && !apbReq.penable) begin
      next_prdata = 32'h00000000;
      case (apbReq.paddr)
        NID_OFS_ID_LOW:    next_prdata = nodeIdLow;
        NID_OFS_ROM_BASE:  next_prdata = romBase;
        NID_OFS_ID_STATUS: begin
          next_prdata[NID_ST_LOCKED]    = idState == NID_LOCKED;
          next_prdata[NID_ST_FROM_SROM] = sromAtReset;
        end
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idState      <= NID_EMPTY;
      nodeIdLow    <= NID_ID_LOW_RST;
      nodeIdLocked <= 1'b0;
      romBase      <= NID_ROM_BASE_RST;
      pready       <= 1'b0;
      prdata       <= 32'h00000000;
      pslverr      <= 1'b0;
    end else begin
      idState      <= next_idState;
      nodeIdLow    <= next_nodeIdLow;
      nodeIdLocked <= next_idState == NID_LOCKED;
      romBase      <= next_romBase;
      pready       <= next_pready;
      prdata       <= next_prdata;
      pslverr      <= next_pslverr;
    end
  end

  nid_rom_addr u_romAddr (
    .core_clk      (core_clk),
    .rst_b         (rst_b),
    .reqValid      (romReqValid),
    .reqOffset     (romReqOffset),
    .romBase       (romBase),
    .hostAddrValid (romHostAddrValid),
    .hostAddr      (romHostAddr)
  );

  a_id_locked_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    idState == NID_LOCKED |=> $stable(nodeIdLow) && idState == NID_LOCKED)
    else $error("locked identifier changed");

  a_id_sw_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    idState == NID_EMPTY && sromCaught && !sromAtReset && wrId
    |=> nodeIdLow == $past(apbReq.pwdata) && nodeIdLocked)
    else $error("first identifier write not taken");

  a_id_srom_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    idState == NID_SROM_LD && sromLoadValid
    |=> nodeIdLow == $past(sromLoadData) && nodeIdLocked)
    else $error("serial ROM load not taken");

  a_srom_enter: assert property (@(posedge core_clk) disable iff (!rst_b)
    idState == NID_EMPTY && sromCaught && sromAtReset
    |=> idState == NID_SROM_LD)
    else $error("serial ROM strap not acted on");

  a_strap_once: assert property (@(posedge core_clk) disable iff (!rst_b)
    sromCaught |=> sromCaught && $stable(sromAtReset))
    else $error("serial ROM strap changed after capture");

  a_id_srom_nosw: assert property (@(posedge core_clk) disable iff (!rst_b)
    idState == NID_SROM_LD && !sromLoadValid |=> $stable(nodeIdLow))
    else $error("identifier changed before serial ROM load");

  a_id_reset_zero: assert property (@(posedge core_clk)
    $rose(rst_b) |-> nodeIdLow == 32'h00000000)
    else $error("identifier not cleared by reset");

  a_rom_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    romBase[NID_ROM_RSVD_W-1:0] == 10'h000)
    else $error("reserved mapping bits not zero");

  a_rom_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wrRom |=> romBase[31:10] == $past(apbReq.pwdata[31:10]))
    else $error("mapping write lost");

  a_id_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    apbReq.psel && !apbReq.penable && !apbReq.pwrite &&
    apbReq.paddr == NID_OFS_ID_LOW
    |=> pready && prdata == $past(nodeIdLow))
    else $error("identifier read wrong");
endmodule
`default_nettype wire

// ==== dv/nid_far_node.sv ====
// Remote node model: issues config ROM quadlet reads toward the block.
// Assumes the bench commands each request on core_clk.
`timescale 1ns/10ps
`default_nettype none
module nid_far_node (
  // Clock and command
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [9:0] off,
  // Request to the block
  output var  logic       romReqValid,
  output var  logic [9:0] romReqOffset
);
  initial begin
    romReqValid = 1'b0;
    romReqOffset = 10'h000;
  end
  // Offset is not held between requests, so a stale value cannot pass
  always @(posedge core_clk) begin
    romReqValid <= go;
    romReqOffset <= go ? off : ~romReqOffset;
  end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Bench for the identifier low and config ROM mapping registers.
// Assumes nid_regs with an APB slave and the remote node model.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import nid_pkg::*;
  logic         core_clk, rst_b, sromPresent, sromLoadValid, go;
  logic         pready, pslverr, romReqValid, romHostAddrValid;
  logic         nodeIdLocked;
  logic [31:0]  sromLoadData, prdata, romHostAddr, nodeIdLow, base, a;
  logic [9:0]   off, romReqOffset;
  nid_apb_req_t apbReq;
  logic [32:0]  q[$], rq[$];
  int           n_fail, tests_run;

  nid_regs uut (.core_clk(core_clk), .rst_b(rst_b), .apbReq(apbReq),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sromPresent(sromPresent), .sromLoadValid(sromLoadValid),
    .sromLoadData(sromLoadData), .romReqValid(romReqValid),
    .romReqOffset(romReqOffset), .romHostAddrValid(romHostAddrValid),
    .romHostAddr(romHostAddr), .nodeIdLow(nodeIdLow),
    .nodeIdLocked(nodeIdLocked));
  nid_far_node far (.core_clk(core_clk), .go(go), .off(off),
    .romReqValid(romReqValid), .romReqOffset(romReqOffset));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, g, e);
    end
  endtask

  task finish_test;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int i;
    apbReq <= '{1'b1, 1'b0, w, ad, d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      chk(33'h0, 33'h1);
      finish_test();
    end
    apbReq <= '0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
                    input logic er = 1'b0);
    q.push_back({er, e});
    apb(1'b0, ad, 32'h0);
  endtask

  task automatic rom(input logic [9:0] o);
    go <= 1'b1;
    off <= o;
    rq.push_back({1'b0, base + {22'h0, o}});
    @(posedge core_clk);
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask

  // Read results in issue order
  always @(posedge core_clk)
    if (pready === 1'b1 && apbReq.pwrite === 1'b0) begin
      if (q.size() == 0) chk(33'h0, 33'h1);
      else chk({pslverr, prdata}, q.pop_front());
    end
  always @(posedge core_clk)
    if (romHostAddrValid === 1'b1) begin
      if (rq.size() == 0) chk(33'h0, 33'h1);
      else chk({1'b0, romHostAddr}, rq.pop_front());
    end

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_b = 1'b0;
    apbReq = '0;
    sromPresent = 1'b0;
    sromLoadValid = 1'b0;
    sromLoadData = 32'h0;
    go = 1'b0;
    off = 10'h0;
    void'($urandom(26));
    do_reset();
    rd(NID_OFS_ID_LOW, NID_ID_LOW_RST);
    rd(NID_OFS_ROM_BASE, NID_ROM_BASE_RST);
    base = $urandom;
    apb(1'b1, NID_OFS_ROM_BASE, base);
    base = base & NID_ROM_BASE_MASK;
    rd(NID_OFS_ROM_BASE, base);
    rom(10'h3ff);
    rom(10'h000);
    rom(10'($urandom));
    a = $urandom;
    apb(1'b1, NID_OFS_ID_LOW, a);
    rd(NID_OFS_ID_LOW, a);
    chk({nodeIdLocked, nodeIdLow}, {1'b1, a});
    apb(1'b1, NID_OFS_ID_LOW, ~a);
    rd(NID_OFS_ID_LOW, a);
    rd(8'h10, 32'h0, 1'b1);
    rd(NID_OFS_ID_STATUS, 32'h1);
    // Second run with the serial ROM fitted
    sromPresent <= 1'b1;
    do_reset();
    rd(NID_OFS_ID_LOW, NID_ID_LOW_RST);
    apb(1'b1, NID_OFS_ID_LOW, 32'h5a5a5a5a);
    rd(NID_OFS_ID_LOW, NID_ID_LOW_RST);
    a = $urandom;
    sromLoadData <= a;
    sromLoadValid <= 1'b1;
    @(posedge core_clk);
    sromLoadValid <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(NID_OFS_ID_LOW, a);
    apb(1'b1, NID_OFS_ID_LOW, ~a);
    rd(NID_OFS_ID_LOW, a);
    rd(NID_OFS_ID_STATUS, 32'h3);
    if (q.size() != 0 || rq.size() != 0) chk(33'h0, 33'h1);
    finish_test();
  end
endmodule
`default_nettype wire
